// >>> inc/icas_defs.svh
// constant names for the isa cycle and address steering block
// assumes inclusion by bare name from rtl files
`ifndef ICAS_DEFS_SVH
`define ICAS_DEFS_SVH
`define ICAS_CLK_NS        8
`define ICAS_REFRESH_NS    15000
`define ICAS_REFRESH_CYC   (`ICAS_REFRESH_NS / `ICAS_CLK_NS)
`define ICAS_READY_WAIT    4'h3
`define ICAS_ONE_MEG_BIT   20
`define ICAS_SIXTEEN_MEG   24
`define ICAS_NMI_PORT      8'h70
`define ICAS_NMI_BIT       7
`define ICAS_A20           20
`define ICAS_LA_LO         17
`endif

// >>> inc/icas_pkg.sv
// types for the isa cycle and address steering block
// assumes icas_defs.svh on the include path
package icas_pkg;
  typedef enum logic [2:0] {
    ICAS_IDLE,
    ICAS_BUSY,
    ICAS_DONE,
    ICAS_END
  } icas_state_t;
  typedef enum logic [2:0] {
    ICAS_CYC_NONE,
    ICAS_CYC_MEMRD,
    ICAS_CYC_MEMWR,
    ICAS_CYC_IORD,
    ICAS_CYC_IOWR,
    ICAS_CYC_INTA
  } icas_cycle_t;
endpackage

// >>> rtl/icas_steer.sv
// isa cycle control and address steering, one clock domain
// assumes i_sys_clk samples the bus clock, status, memory/io, latch, block-a20, error and request pins through two flops; falling
// bus clock edges are found from the synchronised main_bus_clock
//
// Notes on behaviour
// - strap high: word address with byte-high; low: four byte enables, 26 bits
// - cpu mode: local address in, slot address and commands out
// - dma and refresh: commands, local and slot address all driven
// - master mode: drive local address from slot buses, skip sa 17-19
// - nmi on parity error or channel check when each is enabled
// - nmi off after reset; on when port 70h bit 7 written 0
// - status pins: 0 alone write, 1 alone read, both inta
// - status synchronised; under hold grant become memory strobes out
// - memory/io select sampled when a status is active
// - early latch transparent when low, frozen high; upper bits to la
// - internal ale latches lower bits again onto sa and byte-high
// - channel ready asserted idle, negated on request, reasserted to end
// - commands end on next falling bus clock after ready reasserted
// - status and local address inputs sampled on falling main bus clock edges
// - cpu mode with block-a20 active forces latched bit 20 low on la only, not in the 1 Mbyte decode
// - hold request follows a valid dma request
// - 15 us refresh tick offered as refresh request
// - narrow rom low: 8-to-16 conversion; high: 16-bit rom buffers
// - commands input only for master; cpu logic or dma drives else
// - no slot memory read for dma above 16 Mbyte
// - low-memory strobes below 1 Mbyte and refresh, else floated
`timescale 1ns/1ns
`include "icas_defs.svh"
module icas_steer #(
  parameter int REFRESH_CYC = `ICAS_REFRESH_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_main_bus_clock,
  input  wire logic        i_cpu_type_strap,
  input  wire logic        i_processor_hold_grant,
  input  wire logic        i_dma_hold_grant,
  input  wire logic        i_master_n,
  input  wire logic        i_refresh_cycle,
  input  wire logic        i_chan_status0_mem_write_n,
  input  wire logic        i_chan_status1_mem_read_n,
  input  wire logic        i_chan_mem_io_select,
  input  wire logic        i_early_addr_latch_n,
  input  wire logic        i_block_addr20_n,
  input  wire logic        i_narrow_rom_select_n,
  input  wire logic        i_parity_error_n,
  input  wire logic        i_chan_check_n,
  input  wire logic        i_dma_request,
  input  wire logic [25:0] i_dma_addr,
  input  wire logic        i_dma_mem_read_n,
  input  wire logic        i_dma_mem_write_n,
  input  wire logic        i_dma_io_read_n,
  input  wire logic        i_dma_io_write_n,
  input  wire logic [25:0] i_local_addr,
  input  wire logic [3:0]  i_byte_en_n,
  input  wire logic [23:17] i_la,
  input  wire logic [19:0] i_sa,
  input  wire logic [3:0]  i_cmd_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  output logic      [25:0] o_local_addr,
  output logic      [3:0]  o_byte_en_n,
  output logic             o_local_addr_oe,
  output logic      [23:17] o_la,
  output logic      [19:0] o_sa,
  output logic             o_sbhe_n,
  output logic             o_slot_addr_oe,
  output logic      [3:0]  o_cmd_n,
  output logic             o_cmd_oe,
  output logic             o_status_strobe_n_0,
  output logic             o_status_strobe_n_1,
  output logic             o_status_oe,
  output logic             o_low_mem_read_n,
  output logic             o_low_mem_write_n,
  output logic             o_low_mem_oe,
  output logic             o_chan_ready_n,
  output logic             o_nmi,
  output logic             o_dma_hold_request,
  output logic             o_refresh_tick,
  output logic             o_rom_convert,
  output logic             o_rom_wide_buf
);
  // ==========================================================
  // state
  // cmd bits: 0 memr, 1 memw, 2 ior, 3 iow (all active low)
  typedef struct packed {
    logic [1:0]  bclk;
    logic [1:0]  s0;
    logic [1:0]  s1;
    logic [1:0]  mio;
    logic [1:0]  early_addr_latch_n;
    logic [1:0]  blk;
    logic [1:0]  par;
    logic [1:0]  chk;
    logic [1:0]  dreq;
    logic        bclk_q;
    icas_pkg::icas_state_t st;
    icas_pkg::icas_cycle_t cyc;
    logic [3:0]  wait_cnt;
    logic [25:0] early;
    logic [3:0]  early_be;
    logic [19:0] sa;
    logic        sbhe_n;
    logic [3:0]  cmd_n;
    logic        rdy_n;
    logic        nmi_en;
    logic        par_en;
    logic        chk_en;
    logic        nmi;
    logic        hrq;
    logic [15:0] ref_cnt;
    logic        ref_tick;
    logic [7:0]  rdata;
  } icas_state_s_t;
  icas_state_s_t s_q, s_d;

  // ==========================================================
  // decode helpers
  function automatic icas_pkg::icas_cycle_t status_decode(
    input logic s0_n, input logic s1_n, input logic mem);
    icas_pkg::icas_cycle_t c;
    c = icas_pkg::ICAS_CYC_NONE;
    if (!s0_n && !s1_n) c = icas_pkg::ICAS_CYC_INTA;
    else if (!s0_n) c = mem ? icas_pkg::ICAS_CYC_MEMWR
                            : icas_pkg::ICAS_CYC_IOWR;
    else if (!s1_n) c = mem ? icas_pkg::ICAS_CYC_MEMRD
                            : icas_pkg::ICAS_CYC_IORD;
    return c;
  endfunction

  function automatic logic [3:0] cmd_of(input icas_pkg::icas_cycle_t c);
    case (c)
      icas_pkg::ICAS_CYC_MEMRD: cmd_of = 4'hE;
      icas_pkg::ICAS_CYC_MEMWR: cmd_of = 4'hD;
      icas_pkg::ICAS_CYC_IORD:  cmd_of = 4'hB;
      icas_pkg::ICAS_CYC_IOWR:  cmd_of = 4'h7;
      default:                  cmd_of = 4'hF;
    endcase
  endfunction

  // ==========================================================
  // mode decode
  logic cpu_mode, master_mode, dma_mode, fall, below_1m;
  logic [25:0] cur_addr;
  logic [25:0] addr_now;
  logic [3:0]  be_now;
  always_comb begin
    cpu_mode    = !i_processor_hold_grant;
    master_mode = i_processor_hold_grant && !i_master_n;
    dma_mode    = i_processor_hold_grant && i_master_n;
    fall        = s_q.bclk_q && !s_q.bclk[1];
    // upper bits kept from the early latch, sa only holds twenty
    cur_addr    = dma_mode ? i_dma_addr : {s_q.early[25:20], s_q.sa};
    // open latch passes the pins straight through to the second latch
    addr_now    = s_q.early_addr_latch_n[1] ? s_q.early : i_local_addr;
    be_now      = s_q.early_addr_latch_n[1] ? s_q.early_be : i_byte_en_n;
    below_1m    = (cur_addr >> `ICAS_ONE_MEG_BIT) == 26'h0000000;
  end

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    // two-flop pin sync; only bit 1 is read by logic
    s_d.bclk = {s_q.bclk[0], i_main_bus_clock};
    s_d.s0   = {s_q.s0[0], i_chan_status0_mem_write_n};
    s_d.s1   = {s_q.s1[0], i_chan_status1_mem_read_n};
    s_d.mio  = {s_q.mio[0], i_chan_mem_io_select};
    s_d.early_addr_latch_n = {s_q.early_addr_latch_n[0], i_early_addr_latch_n};
    s_d.blk  = {s_q.blk[0], i_block_addr20_n};
    s_d.par  = {s_q.par[0], i_parity_error_n};
    s_d.chk  = {s_q.chk[0], i_chan_check_n};
    s_d.dreq = {s_q.dreq[0], i_dma_request};
    s_d.bclk_q = s_q.bclk[1];
    // early latch, transparent while low
    if (fall && !s_q.early_addr_latch_n[1] && cpu_mode) begin
      s_d.early    = i_local_addr;
      s_d.early_be = i_byte_en_n;
    end
    if (fall) begin
      case (s_q.st)
        icas_pkg::ICAS_IDLE: begin
          s_d.rdy_n = 1'b0;
          if (cpu_mode && (!s_q.s0[1] || !s_q.s1[1])) begin
            s_d.cyc = status_decode(s_q.s0[1], s_q.s1[1], s_q.mio[1]);
            // internal ale: second latch of the lower bits
            s_d.sa = addr_now[19:0];
            if (!i_cpu_type_strap)
              s_d.sbhe_n = &be_now[3:2] ? 1'b1
                         : !(be_now[1] && !be_now[0]);
            else
              s_d.sbhe_n = be_now[1];
            s_d.rdy_n = 1'b1;
            s_d.wait_cnt = `ICAS_READY_WAIT;
            s_d.st = icas_pkg::ICAS_BUSY;
          end
        end
        icas_pkg::ICAS_BUSY: begin
          s_d.cmd_n = cmd_of(s_q.cyc);
          if (s_q.wait_cnt == 4'h0) begin
            s_d.rdy_n = 1'b0;
            s_d.st = icas_pkg::ICAS_DONE;
          end else begin
            s_d.wait_cnt = s_q.wait_cnt - 4'h1;
          end
        end
        icas_pkg::ICAS_DONE: begin
          s_d.cmd_n = 4'hF;
          s_d.cyc = icas_pkg::ICAS_CYC_NONE;
          s_d.st = icas_pkg::ICAS_END;
        end
        icas_pkg::ICAS_END: begin
          // wait for status release before next request
          if (s_q.s0[1] && s_q.s1[1]) s_d.st = icas_pkg::ICAS_IDLE;
        end
        default: s_d.st = icas_pkg::ICAS_IDLE;
      endcase
    end
    // leaving cpu mode drops any half cycle
    if (!cpu_mode) begin
      s_d.st = icas_pkg::ICAS_IDLE;
      s_d.cmd_n = 4'hF;
      s_d.rdy_n = 1'b0;
    end
    // nmi control port, bit 7 low enables
    if (i_wr && i_addr == `ICAS_NMI_PORT)
      s_d.nmi_en = !i_wdata[`ICAS_NMI_BIT];
    if (i_wr && i_addr == `ICAS_NMI_PORT + 8'h01) begin
      s_d.par_en = i_wdata[0];
      s_d.chk_en = i_wdata[1];
    end
    s_d.nmi = s_q.nmi_en && ((s_q.par_en && !s_q.par[1]) ||
                             (s_q.chk_en && !s_q.chk[1]));
    s_d.hrq = s_q.dreq[1];
    // refresh period counter
    // one pulse per period, so the period is the full count
    s_d.ref_tick = 1'b0;
    if (s_q.ref_cnt == 16'(REFRESH_CYC - 1)) begin
      s_d.ref_cnt = 16'h0000;
      s_d.ref_tick = 1'b1;
    end else begin
      s_d.ref_cnt = s_q.ref_cnt + 16'h0001;
    end
    s_d.rdata = 8'h00;
    if (i_rd && i_addr == `ICAS_NMI_PORT + 8'h01)
      s_d.rdata = {4'h0, !s_q.chk[1], !s_q.par[1],
                   s_q.chk_en, s_q.par_en};
    else if (i_rd && i_addr == `ICAS_NMI_PORT)
      s_d.rdata = {!s_q.nmi_en, 7'h00};
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.st <= icas_pkg::ICAS_IDLE;
      s_q.cyc <= icas_pkg::ICAS_CYC_NONE;
      s_q.cmd_n <= 4'hF;
      s_q.sbhe_n <= 1'b1;
      s_q.nmi_en <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // pin steering
  logic [25:0] early20;
  always_comb begin
    early20 = s_q.early;
    if (cpu_mode && !s_q.blk[1]) early20[`ICAS_A20] = 1'b0;
    o_rdata  = s_q.rdata;
    o_nmi    = s_q.nmi;
    o_dma_hold_request = s_q.hrq;
    o_refresh_tick = s_q.ref_tick;
    o_chan_ready_n = s_q.rdy_n;
    o_rom_convert  = !i_narrow_rom_select_n;
    o_rom_wide_buf = i_narrow_rom_select_n;
    o_local_addr_oe = !cpu_mode;
    o_slot_addr_oe  = !master_mode;
    o_cmd_oe        = !master_mode;
    o_status_oe     = !cpu_mode;
    o_byte_en_n = 4'hF;
    if (master_mode) begin
      o_local_addr = {2'b00, i_la, s_q.early[16:0]};
      o_local_addr[16:0] = i_sa[16:0];
    end else if (dma_mode) begin
      o_local_addr = i_refresh_cycle ? {6'h00, i_sa} : i_dma_addr;
      if (i_cpu_type_strap) o_local_addr[25:24] = 2'b00;
    end else begin
      o_local_addr = 26'h0000000;
    end
    o_la = dma_mode ? i_dma_addr[23:17] : early20[23:17];
    o_sa = dma_mode ? i_dma_addr[19:0] : s_q.sa;
    o_sbhe_n = dma_mode ? 1'b0 : s_q.sbhe_n;
    if (dma_mode) begin
      o_cmd_n = {i_dma_io_write_n, i_dma_io_read_n, i_dma_mem_write_n,
                 i_dma_mem_read_n | (i_dma_addr[25:24] != 2'b00)};
    end else begin
      o_cmd_n = s_q.cmd_n;
    end
    o_status_strobe_n_0 = master_mode ? i_cmd_n[1] : o_cmd_n[1];
    o_status_strobe_n_1 = master_mode ? i_cmd_n[0] : o_cmd_n[0];
    o_low_mem_oe = below_1m || i_refresh_cycle;
    o_low_mem_read_n  = !(o_low_mem_oe && !o_cmd_n[0]) && !i_refresh_cycle;
    o_low_mem_write_n = !(below_1m && !o_cmd_n[1]);
  end
endmodule

// >>> test/icas_steer_properties.sv
// assertions on the ports of the steering block
// assumes the bind at the foot of this file reaches icas_steer
`timescale 1ns/1ns
// ====================================================
// port watcher
module icas_steer_properties #(
  parameter int REFRESH_CYC = 8
) (
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       i_processor_hold_grant,
  input wire logic       i_master_n,
  input wire logic       i_chan_status1_mem_read_n,
  input wire logic       i_parity_error_n,
  input wire logic       i_chan_check_n,
  input wire logic       i_dma_request,
  input wire logic       o_local_addr_oe,
  input wire logic       o_slot_addr_oe,
  input wire logic [3:0] o_cmd_n,
  input wire logic       o_cmd_oe,
  input wire logic       o_chan_ready_n,
  input wire logic       o_nmi,
  input wire logic       o_dma_hold_request
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // modes are held four cycles first; the mode pins drive the enables directly
  cpu_dir_a: assert property (!i_processor_hold_grant [*4] |->
    !o_local_addr_oe && o_slot_addr_oe) else $error("cpu direction");
  dma_drive_a: assert property ((i_processor_hold_grant && i_master_n)
    [*4] |-> o_local_addr_oe && o_slot_addr_oe) else $error("dma drive");
  master_cmd_a: assert property ((i_processor_hold_grant && !i_master_n)
    [*4] |-> !o_cmd_oe && o_local_addr_oe) else $error("master drive");
  ready_neg_a: assert property ($fell(i_chan_status1_mem_read_n) &&
    !i_processor_hold_grant |-> ##[1:16] o_chan_ready_n) else $error("ready");
  ready_hold_a: assert property ($rose(o_chan_ready_n) |=>
    o_chan_ready_n [*8]) else $error("ready too short");
  cmd_end_a: assert property ($fell(o_chan_ready_n) |->
    ##[1:12] o_cmd_n == 4'hF) else $error("command not ended");
  nmi_quiet_a: assert property ((i_parity_error_n && i_chan_check_n)
    [*6] |-> !o_nmi) else $error("nmi without cause");
  hold_req_a: assert property (i_dma_request [*6] |->
    o_dma_hold_request) else $error("hold request missing");
  cover property ($fell(o_chan_ready_n));
  cover property ($rose(o_nmi));
  cover property ($rose(o_dma_hold_request));
endmodule
bind icas_steer icas_steer_properties #(.REFRESH_CYC(REFRESH_CYC))
  props_i (.*);

// >>> test/icas_sysctl_model.sv
// system controller stand-in: bus clock and status handshake
// assumes the block holds its ready output low while idle
`timescale 1ns/1ns
// ====================================================
module icas_sysctl_model #(
  parameter int HOLD_EXTRA = 3
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_go,
  input  wire logic [1:0] i_kind_n,
  input  wire logic       i_chan_ready_n,
  output logic            o_bus_clk = 1'h0,
  output logic            o_s0_n = 1'h1,
  output logic            o_s1_n = 1'h1,
  output logic            o_busy = 1'h0
);
  logic [1:0] div_q = 2'h0;
  logic [1:0] ph_q = 2'h0;
  int         cnt_q = 0;
  // bus clock at a quarter rate, free running as a bus clock does
  always @(posedge i_clk) begin
    div_q <= div_q + 2'h1;
    o_bus_clk <= div_q[1];
  end
  // status stays until ready has gone high and low again
  always @(posedge i_clk) begin
    if (i_rst) begin
      {o_s1_n, o_s0_n} <= 2'h3;
      o_busy <= 1'h0;
    end else if (!o_busy && i_go) begin
      {o_s1_n, o_s0_n} <= i_kind_n;
      o_busy <= 1'h1;
      ph_q <= 2'h0;
      cnt_q <= 0;
    end else if (o_busy) begin
      if (ph_q == 2'h0 && i_chan_ready_n) ph_q <= 2'h1;
      if (ph_q == 2'h1 && !i_chan_ready_n) ph_q <= 2'h2;
      if (ph_q == 2'h2) cnt_q <= cnt_q + 1;
      // a slow controller lets status linger past the end
      if (cnt_q == HOLD_EXTRA) {o_s1_n, o_s0_n} <= 2'h3;
      if (cnt_q == HOLD_EXTRA + 12) o_busy <= 1'h0;
    end
  end
endmodule

// >>> test/test_isa_cycle_address_steering.sv
// self-checking bench for the steering block
// assumes the controller model paces every cpu cycle
`timescale 1ns/1ns
// ====================================================
module test_isa_cycle_address_steering;
  logic i_sys_clk = 1'h0, i_rst = 1'h1, i_main_bus_clock, go = 1'h0, busy;
  logic i_cpu_type_strap = 1'h1, i_processor_hold_grant = 1'h0;
  logic i_dma_hold_grant = 1'h0, i_master_n = 1'h1, i_refresh_cycle = 1'h0;
  logic i_chan_status0_mem_write_n, i_chan_status1_mem_read_n;
  logic i_chan_mem_io_select = 1'h1, i_early_addr_latch_n = 1'h0;
  logic i_block_addr20_n = 1'h1, i_narrow_rom_select_n = 1'h1;
  logic i_parity_error_n = 1'h1, i_chan_check_n = 1'h1, i_dma_request = 1'h0;
  logic i_dma_mem_read_n = 1'h1, i_dma_mem_write_n = 1'h1;
  logic i_dma_io_read_n = 1'h1, i_dma_io_write_n = 1'h1;
  logic [25:0] i_dma_addr = '0, i_local_addr = '0, o_local_addr;
  logic [3:0] i_byte_en_n = 4'hE, i_cmd_n = 4'hF, o_byte_en_n, o_cmd_n;
  logic [23:17] i_la = '0, o_la;
  logic [19:0] i_sa = '0, o_sa;
  logic [7:0] i_addr = '0, i_wdata = '0, o_rdata;
  logic i_wr = 1'h0, i_rd = 1'h0, o_sbhe_n, o_status_oe, o_cmd_oe;
  logic o_local_addr_oe, o_slot_addr_oe, o_status_strobe_n_0;
  logic o_status_strobe_n_1, o_low_mem_read_n, o_low_mem_write_n;
  logic o_low_mem_oe, o_chan_ready_n, o_nmi, o_dma_hold_request;
  logic o_refresh_tick, o_rom_convert, o_rom_wide_buf;
  logic [1:0] kind_n = 2'h3;
  wire [3:0] dirs = {o_local_addr_oe, o_slot_addr_oe, o_cmd_oe, o_status_oe};
  int fails = 0, samples_checked = 0, ticks = 0, rises = 0, n;
  icas_steer #(.REFRESH_CYC(8)) icas_steer_i (.*);
  icas_sysctl_model icas_sysctl_model_i (.i_clk(i_sys_clk), .i_rst,
    .i_go(go), .i_kind_n(kind_n), .i_chan_ready_n(o_chan_ready_n),
    .o_bus_clk(i_main_bus_clock), .o_s0_n(i_chan_status0_mem_write_n),
    .o_s1_n(i_chan_status1_mem_read_n), .o_busy(busy));
  always #4 i_sys_clk = ~i_sys_clk;
  always @(posedge o_refresh_tick) rises++;
  // ceiling far above the few hundred cycles of the run
  always @(posedge i_sys_clk) begin
    ticks++;
    if (ticks == 20000) begin
      fails++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    {i_addr, i_wdata, i_wr} <= {a, d, 1'h1};
    @(posedge i_sys_clk);
    i_wr <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge i_sys_clk);
    {i_addr, i_rd} <= {a, 1'h1};
    @(posedge i_sys_clk);
    i_rd <= 1'h0;
    @(negedge i_sys_clk);
    chk(o_rdata & m, e);
  endtask
  task automatic settle;
    repeat (8) @(posedge i_sys_clk);
  endtask
  // one cpu cycle; command looked at once ready is back low
  task automatic run_cyc(input logic [1:0] k, input logic m,
                         input logic [25:0] a, input logic [3:0] e);
    @(posedge i_sys_clk);
    {i_local_addr, i_chan_mem_io_select, kind_n, go} <= {a, m, k, 1'h1};
    @(posedge i_sys_clk);
    go <= 1'h0;
    wait (o_chan_ready_n === 1'h1);
    wait (o_chan_ready_n === 1'h0);
    @(negedge i_sys_clk);
    chk(o_cmd_n, e);
    chk(o_sa, a[19:0]);
    if (m && a < 26'h10_0000) chk({o_low_mem_oe, o_low_mem_read_n,
      o_low_mem_write_n}, {1'h1, k});
    else if (m) chk(o_low_mem_oe, 1'h0);
    while (busy) @(posedge i_sys_clk);
    chk({o_chan_ready_n, o_cmd_n}, 5'h0F);
  endtask
  task automatic final_report;
    $display("compared %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    settle;
    run_cyc(2'h1, 1'h1, 26'h00_1234, 4'hE);
    run_cyc(2'h2, 1'h1, 26'h0F_5678, 4'hD);
    run_cyc(2'h1, 1'h0, 26'h00_0060, 4'hB);
    run_cyc(2'h2, 1'h0, 26'h00_0061, 4'h7);
    run_cyc(2'h0, 1'h0, 26'h00_0000, 4'hF);
    run_cyc(2'h1, 1'h1, 26'h10_0000, 4'hE);
    {i_local_addr, i_block_addr20_n} <= {26'h1F_0000, 1'h0};
    settle;
    chk(o_la, 7'h07);
    chk(dirs, 4'h6);
    i_block_addr20_n <= 1'h1;
    settle;
    chk(o_la, 7'h0F);
    i_early_addr_latch_n <= 1'h1;
    settle;
    i_local_addr <= '0;
    settle;
    chk(o_la, 7'h0F);
    i_early_addr_latch_n <= 1'h0;
    rd(8'h00, 8'hFF, 8'h00);
    chk({o_rom_convert, o_rom_wide_buf}, 2'h1);
    wr(8'h71, 8'h03);
    rd(8'h71, 8'h03, 8'h03);
    i_parity_error_n <= 1'h0;
    settle;
    chk(o_nmi, 1'h0);
    wr(8'h70, 8'h00);
    rd(8'h70, 8'h80, 8'h00);
    settle;
    chk(o_nmi, 1'h1);
    {i_parity_error_n, i_chan_check_n} <= 2'h2;
    wr(8'h71, 8'h01);
    settle;
    chk(o_nmi, 1'h0);
    wr(8'h71, 8'h02);
    settle;
    chk(o_nmi, 1'h1);
    i_chan_check_n <= 1'h1;
    {i_processor_hold_grant, i_dma_hold_grant, i_dma_request} <= 3'h7;
    {i_dma_addr, i_dma_mem_read_n} <= {26'h100_0000, 1'h0};
    settle;
    chk(o_cmd_n, 4'hF);
    chk(dirs, 4'hF);
    chk(o_dma_hold_request, 1'h1);
    i_dma_addr <= 26'h0FF_FFFF;
    settle;
    chk(o_cmd_n, 4'hE);
    {i_dma_mem_read_n, i_refresh_cycle} <= 2'h3;
    settle;
    chk({o_low_mem_oe, o_low_mem_read_n}, 2'h2);
    {i_refresh_cycle, i_master_n, i_sa, i_la} <= {2'h0, 20'hABCDE, 7'h55};
    settle;
    chk(o_local_addr[23:0], 24'hAA_BCDE);
    chk(dirs[3:1], 3'h4);
    {i_processor_hold_grant, i_master_n, i_dma_request} <= 3'h2;
    n = rises;
    repeat (80) @(posedge i_sys_clk);
    chk((rises - n) inside {[9:11]}, 1'h1);
    final_report;
  end
endmodule
